/* common/sensor_reference_clock_out_cfg.svh */
// Register offsets, reset values and timing for the config bank
`ifndef SENSOR_REFERENCE_CLOCK_OUT_BANK_CFG_SVH
`define SENSOR_REFERENCE_CLOCK_OUT_BANK_CFG_SVH
`define OFS_CLK_PREDIV_M 8'h06
`define OFS_CLK_N 8'h07
`define OFS_CHAN_WDOG 8'h08
`define OFS_I2C_LOCAL 8'h09
`define RST_CLK_PREDIV_M 8'h41
`define RST_CLK_N 8'h28
`define RST_CHAN_WDOG 8'hfe
`define RST_I2C_LOCAL 8'h1e
`define WDOG_STEP_NS 2000000
`define HOLD_STEP_NS 50
`define FILT_STEP_NS 5
`define CLK_PERIOD_NS 10
`endif

/* common/sensor_reference_clock_out_pkg.sv */
// Types shared by the config bank
package sensor_reference_clock_out_pkg;
  typedef enum logic [1:0] {
    WD_IDLE = 2'b01,
    WD_RUN = 2'b10
  } wdog_state_t;
endpackage

/* hdl/sensor_reference_clock_out_bank.sv */
// Clock output, channel watchdog, write protect and I2C input conditioning bank
// Overview of operation
// - Predivider codes 0-4 divide by 1..16
// - Output clock is predivided clock times M/(2N)
// - M of zero holds output static
// - Watchdog timeout field counts 2 ms steps
// - Abort transactions exceeding the watchdog timeout
// - Disable bit 1 stops watchdog, reset 0
// - Write protect rejects remote register writes
// - Remote accesses to local targets still pass
// - SDA input held per 50 ns steps
// - Glitches filtered per 5 ns steps
`include "sensor_reference_clock_out_cfg.svh"
module sensor_reference_clock_out_bank #(
  parameter int WDOG_STEP_CYC = `WDOG_STEP_NS / `CLK_PERIOD_NS
) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_hs_clk_tick,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_remote,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata,
  output logic o_wr_rejected,
  input wire logic i_chan_begin,
  input wire logic i_chan_done,
  output logic o_chan_abort,
  input wire logic i_remote_pass_req,
  output logic o_remote_pass_req,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda,
  output logic o_sensor_reference_clock_out
);
  localparam int HOLD_STEP_CYC = (`HOLD_STEP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam int FILT_STEP_NS = `FILT_STEP_NS;
  localparam int PERIOD_NS = `CLK_PERIOD_NS;

  logic [7:0] prediv_m_r;
  logic [7:0] n_val_r;
  logic [7:0] wdog_r;
  logic [7:0] i2c_local_r;
  logic [7:0] rdata_r;
  logic rej_r;
  logic wr_ok;

  // Register select and readback value
  function automatic logic [7:0] reg_read(input logic [7:0] a, input logic [7:0] p,
      input logic [7:0] n, input logic [7:0] w, input logic [7:0] c);
    case (a)
      `OFS_CLK_PREDIV_M: reg_read = p;
      `OFS_CLK_N: reg_read = n;
      `OFS_CHAN_WDOG: reg_read = w;
      `OFS_I2C_LOCAL: reg_read = c;
      default: reg_read = 8'h00;
    endcase
  endfunction

  // Remote writes blocked while protect bit set
  assign wr_ok = i_wr && !(i_remote && i2c_local_r[7]);

  // Register writes
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      prediv_m_r <= `RST_CLK_PREDIV_M;
      n_val_r <= `RST_CLK_N;
      wdog_r <= `RST_CHAN_WDOG;
      i2c_local_r <= `RST_I2C_LOCAL;
    end else if (wr_ok) begin
      case (i_addr)
        `OFS_CLK_PREDIV_M: prediv_m_r <= i_wdata;
        `OFS_CLK_N: n_val_r <= i_wdata;
        `OFS_CHAN_WDOG: wdog_r <= i_wdata;
        `OFS_I2C_LOCAL: i2c_local_r <= i_wdata;
        default: ;
      endcase
    end
  end

  // Read data and reject flag
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      rdata_r <= 8'h00;
      rej_r <= 1'b0;
    end else begin
      if (i_rd) begin
        rdata_r <= reg_read(i_addr, prediv_m_r, n_val_r, wdog_r, i2c_local_r);
      end
      rej_r <= i_wr && !wr_ok;
    end
  end
  assign o_rdata = rdata_r;
  assign o_wr_rejected = rej_r;

  // Pass-through to local targets unaffected by protection
  assign o_remote_pass_req = i_remote_pass_req;

  // Fast clock predivider: tick every 2^code fast ticks
  logic [15:0] pre_cnt_r;
  logic pre_tick;
  logic [2:0] div_code;
  logic [15:0] pre_mask;
  assign div_code = (prediv_m_r[7:5] > 3'h4) ? 3'h4 : prediv_m_r[7:5];
  // Low bits of the tick count that must be zero for a predivided tick
  assign pre_mask = (16'h0001 << div_code) - 16'h0001;
  assign pre_tick = i_hs_clk_tick && ((pre_cnt_r & pre_mask) == 16'h0000);
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      pre_cnt_r <= 16'h0000;
    end else if (i_hs_clk_tick) begin
      pre_cnt_r <= pre_cnt_r + 16'h0001;
    end
  end

  // M/N accumulator toggles output, toggle rate = pre rate * M / N
  logic [8:0] acc_r;
  logic out_r;
  logic [8:0] acc_sum;
  assign acc_sum = acc_r + {4'h0, prediv_m_r[4:0]};
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      acc_r <= 9'h000;
      out_r <= 1'b0;
    end else if (prediv_m_r[4:0] == 5'h00) begin
      acc_r <= 9'h000;
    end else if (pre_tick) begin
      if (acc_sum >= {1'b0, n_val_r}) begin
        acc_r <= acc_sum - {1'b0, n_val_r};
        out_r <= ~out_r;
      end else begin
        acc_r <= acc_sum;
      end
    end
  end
  assign o_sensor_reference_clock_out = out_r;

  // Channel watchdog
  sensor_reference_clock_out_pkg::wdog_state_t wd_state_r;
  logic [31:0] step_cnt_r;
  logic [6:0] wd_steps_r;
  logic abort_r;
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      wd_state_r <= sensor_reference_clock_out_pkg::WD_IDLE;
      step_cnt_r <= 32'h0;
      wd_steps_r <= 7'h00;
      abort_r <= 1'b0;
    end else begin
      abort_r <= 1'b0;
      case (wd_state_r)
        sensor_reference_clock_out_pkg::WD_IDLE: begin
          step_cnt_r <= 32'h0;
          wd_steps_r <= 7'h00;
          if (i_chan_begin && !wdog_r[0]) begin
            wd_state_r <= sensor_reference_clock_out_pkg::WD_RUN;
          end
        end
        sensor_reference_clock_out_pkg::WD_RUN: begin
          if (i_chan_done || wdog_r[0]) begin
            wd_state_r <= sensor_reference_clock_out_pkg::WD_IDLE;
          end else if (step_cnt_r == 32'(WDOG_STEP_CYC - 1)) begin
            step_cnt_r <= 32'h0;
            if (wd_steps_r + 7'h01 >= wdog_r[7:1]) begin
              abort_r <= 1'b1;
              wd_state_r <= sensor_reference_clock_out_pkg::WD_IDLE;
            end else begin
              wd_steps_r <= wd_steps_r + 7'h01;
            end
          end else begin
            step_cnt_r <= step_cnt_r + 32'h1;
          end
        end
        default: wd_state_r <= sensor_reference_clock_out_pkg::WD_IDLE;
      endcase
    end
  end
  assign o_chan_abort = abort_r;

  // I2C input synchronisers
  logic [1:0] scl_s_r;
  logic [1:0] sda_s_r;
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      scl_s_r <= 2'b11;
      sda_s_r <= 2'b11;
    end else begin
      scl_s_r <= {scl_s_r[0], i_scl};
      sda_s_r <= {sda_s_r[0], i_sda};
    end
  end

  // Glitch limit in cycles, rounded down, at least one
  function automatic logic [7:0] filt_cyc(input logic [3:0] d);
    int c;
    c = (int'(d) * FILT_STEP_NS) / PERIOD_NS;
    filt_cyc = (c < 1) ? 8'h01 : 8'(c);
  endfunction

  // Glitch filters: change accepted after level stable longer than limit
  logic [7:0] scl_cnt_r;
  logic [7:0] sda_cnt_r;
  logic scl_f_r;
  logic sda_f_r;
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      scl_cnt_r <= 8'h00;
      sda_cnt_r <= 8'h00;
      scl_f_r <= 1'b1;
      sda_f_r <= 1'b1;
    end else begin
      if (scl_s_r[1] == scl_f_r) begin
        scl_cnt_r <= 8'h00;
      end else if (scl_cnt_r >= filt_cyc(i2c_local_r[3:0])) begin
        scl_f_r <= scl_s_r[1];
        scl_cnt_r <= 8'h00;
      end else begin
        scl_cnt_r <= scl_cnt_r + 8'h01;
      end
      if (sda_s_r[1] == sda_f_r) begin
        sda_cnt_r <= 8'h00;
      end else if (sda_cnt_r >= filt_cyc(i2c_local_r[3:0])) begin
        sda_f_r <= sda_s_r[1];
        sda_cnt_r <= 8'h00;
      end else begin
        sda_cnt_r <= sda_cnt_r + 8'h01;
      end
    end
  end

  // SDA hold: after SCL falls, SDA change delayed by hold steps
  logic [7:0] hold_cnt_r;
  logic scl_d_r;
  logic sda_out_r;
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      hold_cnt_r <= 8'h00;
      scl_d_r <= 1'b1;
      sda_out_r <= 1'b1;
    end else begin
      scl_d_r <= scl_f_r;
      if (scl_d_r && !scl_f_r) begin
        hold_cnt_r <= 8'(int'(i2c_local_r[6:4]) * HOLD_STEP_CYC);
      end else if (hold_cnt_r != 8'h00) begin
        hold_cnt_r <= hold_cnt_r - 8'h01;
      end else begin
        sda_out_r <= sda_f_r;
      end
    end
  end
  assign o_scl = scl_d_r;
  assign o_sda = sda_out_r;
endmodule

/* tb/far_model.sv */
// Far side: sensor clock sink and channel requester
module far_model (
  input wire logic i_core_clk,
  input wire logic i_ref_clk,
  output logic o_begin = 1'b0,
  output logic o_done = 1'b0,
  output int o_rises = 0
);
  timeunit 1ns;
  timeprecision 1ps;
  logic last_r = 1'b0;
  // Count sensor clock rises
  always @(posedge i_core_clk) begin
    o_rises <= o_rises + int'(i_ref_clk && !last_r);
    last_r <= i_ref_clk;
  end
  // One transaction, never finished when len is 0
  task automatic xact(input int len);
    @(negedge i_core_clk) o_begin = 1'b1;
    @(negedge i_core_clk) o_begin = 1'b0;
    if (len > 0) begin
      repeat (len) @(negedge i_core_clk);
      o_done = 1'b1;
      @(negedge i_core_clk) o_done = 1'b0;
    end
  endtask
endmodule

/* tb/sensor_reference_clock_out_chk_assertions.sv */
// Checker bound to the config bank ports
module sensor_reference_clock_out_chk (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_wr,
  input wire logic i_remote,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic o_wr_rejected,
  input wire logic i_chan_begin,
  input wire logic o_chan_abort,
  input wire logic i_remote_pass_req,
  input wire logic o_remote_pass_req,
  input wire logic i_scl,
  input wire logic o_scl,
  input wire logic o_sensor_reference_clock_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] m_r;
  logic off_r;
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_rst);
  // Shadow of M and watchdog-off from local writes
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      m_r <= 5'h01;
      off_r <= 1'b0;
    end else if (i_wr && !i_remote) begin
      m_r <= (i_addr == 8'h06) ? i_wdata[4:0] : m_r;
      off_r <= (i_addr == 8'h08) ? i_wdata[0] : off_r;
    end
  end
  a_pass_thru: assert property (o_remote_pass_req == i_remote_pass_req) else $error("pass");
  a_rej_cause: assert property (o_wr_rejected |-> $past(i_wr && i_remote)) else $error("rej");
  a_local_ok: assert property (i_wr && !i_remote |=> !o_wr_rejected) else $error("lcl");
  a_abort_pulse: assert property (o_chan_abort |=> !o_chan_abort) else $error("abt");
  a_abort_late: assert property (i_chan_begin |=> !o_chan_abort [*8]) else $error("early");
  a_clk_static: assert property ((m_r == 5'h00) [*4] |-> $stable(o_sensor_reference_clock_out))
    else $error("clk");
  a_scl_filt: assert property ($changed(o_scl) |-> o_scl == $past(i_scl)) else $error("scl");
  a_wd_off: assert property (off_r [*2] |-> !o_chan_abort) else $error("wd");
  cover property (o_wr_rejected);
  cover property (o_chan_abort);
  cover property ($rose(o_sensor_reference_clock_out));
endmodule
bind sensor_reference_clock_out_bank sensor_reference_clock_out_chk i_chk (.i_core_clk, .i_rst, .i_wr, .i_remote, .i_addr, .i_wdata,
  .o_wr_rejected, .i_chan_begin, .o_chan_abort, .i_remote_pass_req, .o_remote_pass_req,
  .i_scl, .o_scl, .o_sensor_reference_clock_out);

/* tb/tb_top.sv */
// Self-checking bench for the config bank
`include "sensor_reference_clock_out_cfg.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, wr, rd, rem, beg, done, abt, rej, pin, pout, scl, scl_o, sda_o, ref_o, low;
  logic tick, sda;
  logic [7:0] addr, wd, rdat;
  int err_total = 0;
  int comparisons = 0;
  int rises, n;
  sensor_reference_clock_out_bank #(.WDOG_STEP_CYC(10)) i_sensor_reference_clock_out_bank (.i_core_clk(clk), .i_rst(rst),
    .i_hs_clk_tick(tick), .i_wr(wr), .i_rd(rd), .i_remote(rem), .i_addr(addr),
    .i_wdata(wd), .o_rdata(rdat), .o_wr_rejected(rej), .i_chan_begin(beg),
    .i_chan_done(done), .o_chan_abort(abt), .i_remote_pass_req(pin),
    .o_remote_pass_req(pout), .i_scl(scl), .i_sda(sda), .o_scl(scl_o),
    .o_sda(sda_o), .o_sensor_reference_clock_out(ref_o));
  far_model i_far (.i_core_clk(clk), .i_ref_clk(ref_o), .o_begin(beg), .o_done(done),
    .o_rises(rises));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic put(input logic r, input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    {wr, rem, addr, wd} = {1'b1, r, a, d};
    @(negedge clk);
    {wr, rem} = 2'b00;
  endtask
  task automatic get(input string what, input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk);
    {rd, addr} = {1'b1, a};
    @(negedge clk);
    rd = 1'b0;
    chk(what, rdat, exp);
  endtask
  task automatic watch(input int lim);
    for (n = 0; abt !== 1'b1 && n < lim; n++) @(negedge clk);
  endtask
  task automatic t_clk;
    int r0, e;
    put(1'b0, `OFS_CLK_N, 8'h08);
    put(1'b0, `OFS_CLK_PREDIV_M, 8'h03);
    // Ratio 3/8 at full and at half tick rate
    for (int k = 0; k < 2; k++) begin
      repeat (40) @(negedge clk) tick = k ? ~tick : 1'b1;
      r0 = rises;
      repeat (320) @(negedge clk) tick = k ? ~tick : 1'b1;
      e = 60 >> k;
      chk("mn rises", (rises - r0 >= e - 1) && (rises - r0 <= e + 1), 1'b1);
    end
    tick = 1'b1;
    put(1'b0, `OFS_CLK_N, 8'h01);
    for (int c = 0; c < 6; c++) begin
      put(1'b0, `OFS_CLK_PREDIV_M, (c < 5) ? {c[2:0], 5'h01} : 8'h40);
      repeat (40) @(negedge clk);
      r0 = rises;
      e = (c < 5) ? (160 >> c) : 0;
      repeat (320) @(negedge clk);
      chk("rises", (rises - r0 >= e - 1) && (rises - r0 <= e + (e > 0)), 1'b1);
    end
    $display("clk done");
  endtask
  task automatic t_wdog;
    put(1'b0, `OFS_CHAN_WDOG, 8'h04);
    i_far.xact(0);
    watch(60);
    chk("abort time", n >= 18 && n <= 24, 1'b1);
    i_far.xact(5);
    watch(60);
    chk("done clears", 8'(n), 8'd60);
    put(1'b0, `OFS_CHAN_WDOG, 8'h05);
    i_far.xact(0);
    watch(60);
    chk("disabled", 8'(n), 8'd60);
    $display("wdog done");
  endtask
  task automatic t_prot;
    put(1'b0, `OFS_I2C_LOCAL, 8'h9e);
    pin = 1'b1;
    put(1'b1, `OFS_CLK_N, 8'h55);
    chk("reject", rej, 1'b1);
    chk("pass", pout, 1'b1);
    get("n kept", `OFS_CLK_N, 8'h01);
    put(1'b0, `OFS_I2C_LOCAL, 8'h1e);
    put(1'b1, `OFS_CLK_N, 8'h55);
    chk("accept", rej, 1'b0);
    get("n set", `OFS_CLK_N, 8'h55);
    $display("prot done");
  endtask
  task automatic t_filt;
    for (int k = 0; k < 2; k++) begin
      if (k == 1) put(1'b0, `OFS_I2C_LOCAL, 8'h11);
      @(negedge clk) scl = 1'b0;
      repeat (k ? 6 : 3) @(negedge clk);
      {scl, low} = 2'b10;
      repeat (20) @(negedge clk) low = low | ~scl_o;
      chk("scl glitch", low, 8'(k));
    end
    $display("filt done");
  endtask
  // SDA change held off after SCL falls, per hold field
  task automatic t_hold;
    int m, e;
    for (int h = 0; h < 2; h++) begin
      put(1'b0, `OFS_I2C_LOCAL, {1'b0, h[2:0], 4'h1});
      repeat (4) @(negedge clk);
      {scl, sda} = 2'b00;
      for (m = 0; scl_o !== 1'b0 && m < 20; m++) @(negedge clk);
      for (m = 0; sda_o !== 1'b0 && m < 20; m++) @(negedge clk);
      e = h * `HOLD_STEP_NS / `CLK_PERIOD_NS;
      chk("sda hold", (m >= e) && (m <= e + 2), 1'b1);
      {scl, sda} = 2'b11;
      repeat (20) @(negedge clk);
      chk("sda back", sda_o, 1'b1);
    end
    $display("hold done");
  endtask
  // Reset in mid-run restores every register
  task automatic t_rst;
    @(negedge clk) rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    get("ctrl0 rst", `OFS_CLK_PREDIV_M, `RST_CLK_PREDIV_M);
    get("ctrl1 rst", `OFS_CLK_N, `RST_CLK_N);
    get("wdog rst", `OFS_CHAN_WDOG, `RST_CHAN_WDOG);
    get("i2c rst", `OFS_I2C_LOCAL, `RST_I2C_LOCAL);
    $display("rst done");
  endtask
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    {rst, wr, rd, rem, addr, wd, pin, scl} = {4'h8, 16'h0000, 2'b01};
    {tick, sda} = 2'b11;
    repeat (4) @(negedge clk);
    rst = 1'b0;
    get("ctrl0", `OFS_CLK_PREDIV_M, `RST_CLK_PREDIV_M);
    get("ctrl1", `OFS_CLK_N, `RST_CLK_N);
    get("wdog", `OFS_CHAN_WDOG, `RST_CHAN_WDOG);
    get("i2c", `OFS_I2C_LOCAL, `RST_I2C_LOCAL);
    get("unmapped", 8'h0a, 8'h00);
    $display("regs done");
    t_clk;
    t_wdog;
    t_prot;
    t_filt;
    t_hold;
    t_rst;
    conclude;
  end
  initial begin
    #100000;
    err_total++;
    conclude;
  end
endmodule
